// >>> acfg_cfg.svh
// Register offsets, field positions and reset values of the configuration bank.
// Assumes inclusion by bare name from the modules and the test bench.
`ifndef ACFG_CFG_SVH
`define ACFG_CFG_SVH
`define ACFG_ADDR_SOFT_RESET 8'h00
`define ACFG_ADDR_READBACK 8'h01
`define ACFG_ADDR_SYNC 8'h02
`define ACFG_ADDR_CLAMP 8'h09
`define ACFG_ADDR_POWER 8'h0F
`define ACFG_ADDR_DRIVE 8'h11
`define ACFG_BIT_SOFT_RESET 0
`define ACFG_BIT_READBACK 0
`define ACFG_BIT_UPPER_ADDR 4
`define ACFG_BIT_SYNC_EN 13
`define ACFG_BIT_CLAMP_EN 10
`define ACFG_BIT_PIN_FUNC 10
`define ACFG_BIT_GLOBAL_POWERDOWN 9
`define ACFG_BIT_STANDBY 8
`define ACFG_MASK_READBACK 16'h0011
`define ACFG_MASK_SYNC 16'h2000
`define ACFG_MASK_CLAMP 16'h0400
`define ACFG_MASK_POWER 16'h07FF
`define ACFG_MASK_DRIVE 16'h0777
`define ACFG_RST_READBACK 16'h0000
`define ACFG_RST_SYNC 16'h0000
`define ACFG_RST_CLAMP 16'h0000
`define ACFG_RST_POWER 16'h0000
`define ACFG_RST_DRIVE 16'h0000
`define ACFG_FRAME_BITS 24
`endif

// >>> acfg_pkg.sv
// Types shared by the configuration bank modules.
// Assumes acfg_cfg.svh is on the include path.
package acfg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } acfg_frame_t;

    typedef struct packed {
        logic pin_is_standby;
        logic global_powerdown;
        logic standby;
        logic [7:0] channel_sleep_bits;
    } acfg_power_t;

    typedef struct packed {
        logic chip_powered;
        logic converters_on;
        logic clocks_running;
        logic [7:0] channel_on;
    } acfg_power_state_t;
endpackage

// >>> acfg_serial_shift.sv
// Serial front end: captures 24-bit frames and shifts readback data out.
// Assumes sclk, sen_n and sdata were synchronised to clock by the caller.
module acfg_serial_shift
    import acfg_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Synchronised serial pins.
    input wire logic sclk_rise,
    input wire logic sclk_fall,
    input wire logic sen_n,
    input wire logic sdata,
    // Readback word.
    input wire logic [15:0] read_data,
    // Frame output.
    output acfg_frame_t frame,
    output logic frame_valid,
    output logic [7:0] cur_addr,
    output logic addr_valid,
    output logic serial_data_output_pin
);
`include "acfg_cfg.svh"
    logic [23:0] shift_reg, shift_next;
    logic [4:0] count_reg, count_next;
    logic [15:0] out_reg, out_next;
    logic valid_reg, valid_next;

    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        out_next = out_reg;
        valid_next = 1'b0;
        if (sen_n) begin
            count_next = 5'h00;
        end else if (sclk_rise) begin
            shift_next = {shift_reg[22:0], sdata};
            count_next = count_reg + 5'h01;
            if (count_reg == 5'(`ACFG_FRAME_BITS - 1)) begin
                valid_next = 1'b1;
            end
        end else if (sclk_fall) begin
            if (count_reg == 5'h08) begin
                out_next = read_data;
            end else if (count_reg > 5'h08) begin
                out_next = {out_reg[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_reg <= 24'h000000;
            count_reg <= 5'h00;
            out_reg <= 16'h0000;
            valid_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            out_reg <= out_next;
            valid_reg <= valid_next;
        end
    end

    assign frame = shift_reg;
    assign frame_valid = valid_reg;
    assign cur_addr = shift_reg[7:0];
    assign addr_valid = (count_reg >= 5'h08);
    assign serial_data_output_pin = out_reg[15];
endmodule // acfg_serial_shift

// >>> acfg_power_ctrl.sv
// Combines power register bits and the power-down pin into power states.
// Assumes the pin level is already synchronised.
module acfg_power_ctrl
    import acfg_pkg::*;
(
    // Settings.
    input acfg_power_t cfg,
    input wire logic powerdown_input,
    // Result.
    output acfg_power_state_t state
);
    logic pin_global;
    logic pin_standby;
    logic global_any;
    logic standby_any;

    always_comb begin
        pin_global = powerdown_input & ~cfg.pin_is_standby;
        pin_standby = powerdown_input & cfg.pin_is_standby;
        global_any = cfg.global_powerdown | pin_global;
        standby_any = cfg.standby | pin_standby;
        state.chip_powered = ~global_any;
        state.clocks_running = ~global_any;
        state.converters_on = ~global_any & ~standby_any;
        for (int i = 0; i < 8; i++) begin
            state.channel_on[i] = state.converters_on &
                ~cfg.channel_sleep_bits[i];
        end
    end
endmodule // acfg_power_ctrl

// >>> acfg_regs.sv
// Configuration register bank of an eight-channel converter.
// Assumes a host drives the three-wire serial port; pins are asynchronous.
//
// How it works
// - Reset leaves 16-bit path on eight channels.
// - Reset leaves 1-wire 16x link, 8x/1x clocks.
// - Reset leaves serial readback disabled.
// - Reset makes power pin global power-down.
// - Reset sets 3.5 mA drive, no termination.
// - Reset sets 0 dB gain, processing off.
// - Soft reset bit restores defaults, self-clears.
// - Readback off keeps data pin high-impedance.
// - Readback on drives register data serially.
// - Sync disabled ignores the sync pin.
// - Sync enabled aligns decimation filters.
// - Clamp bit enables 14-bit input clamp.
// - Clamp action timed by sync pin rising edge, even with sync disabled.
// - Pin function bit picks global or standby.
// - Global power-down stops everything incl. buffers.
// - Standby stops converters, clocks keep running.
// - Channel bits power paths down individually.
module acfg_regs
    import acfg_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Serial configuration pins.
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdata,
    output logic serial_data_output_pin_o,
    output logic serial_data_output_pin_oe,
    // Control pins.
    input wire logic powerdown_input,
    input wire logic sync_pin,
    // Configuration outputs.
    output logic upper_address_enable,
    output logic sync_pulse,
    output logic clamp_enable,
    output logic clamp_strobe,
    output logic [2:0] data_driver_current,
    output logic [15:0] drive_current_word,
    output logic resolution_is_14bit,
    output logic low_freq_noise_suppression,
    output logic [3:0] digital_gain,
    output logic termination_enable,
    output acfg_power_state_t power_state
);
`include "acfg_cfg.svh"
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sclk_s1_reg, sclk_s2_reg;
    logic [3:0] misc_s1_reg, misc_s2_reg;
    logic sclk_d_reg;
    logic sync_d_reg;

    // Reset values match the idle pin levels, so no false edge or
    // power-down follows reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            misc_s1_reg <= 4'h8;
            misc_s2_reg <= 4'h8;
            sclk_d_reg <= 1'b0;
            sync_d_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= sclk;
            sclk_s2_reg <= sclk_s1_reg;
            misc_s1_reg <= {sen_n, sdata, powerdown_input, sync_pin};
            misc_s2_reg <= misc_s1_reg;
            sclk_d_reg <= sclk_s2_reg;
            sync_d_reg <= misc_s2_reg[0];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sync_rise;
    assign sclk_rise = sclk_s2_reg & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_d_reg;
    assign sync_rise = misc_s2_reg[0] & ~sync_d_reg;

    // ------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------
    acfg_frame_t frame;
    logic frame_valid;
    logic [7:0] cur_addr;
    logic addr_valid;
    logic shift_out;
    logic [15:0] read_data;

    acfg_serial_shift u_shift (
        .clock(clock),
        .rst(rst),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall),
        .sen_n(misc_s2_reg[3]),
        .sdata(misc_s2_reg[2]),
        .read_data(read_data),
        .frame(frame),
        .frame_valid(frame_valid),
        .cur_addr(cur_addr),
        .addr_valid(addr_valid),
        .serial_data_output_pin(shift_out)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] readback_reg, readback_next;
    logic [15:0] sync_reg, sync_next;
    logic [15:0] clamp_reg, clamp_next;
    logic [15:0] power_reg, power_next;
    logic [15:0] drive_reg, drive_next;

    always_comb begin
        readback_next = readback_reg;
        sync_next = sync_reg;
        clamp_next = clamp_reg;
        power_next = power_reg;
        drive_next = drive_reg;
        if (frame_valid) begin
            if (frame.addr == `ACFG_ADDR_SOFT_RESET) begin
                // The reset bit is never stored, so it reads back as zero.
                if (frame.data[`ACFG_BIT_SOFT_RESET]) begin
                    readback_next = `ACFG_RST_READBACK;
                    sync_next = `ACFG_RST_SYNC;
                    clamp_next = `ACFG_RST_CLAMP;
                    power_next = `ACFG_RST_POWER;
                    drive_next = `ACFG_RST_DRIVE;
                end
            end else if (frame.addr == `ACFG_ADDR_READBACK) begin
                readback_next = frame.data & `ACFG_MASK_READBACK;
            end else if (frame.addr == `ACFG_ADDR_SYNC) begin
                sync_next = frame.data & `ACFG_MASK_SYNC;
            end else if (frame.addr == `ACFG_ADDR_CLAMP) begin
                clamp_next = frame.data & `ACFG_MASK_CLAMP;
            end else if (frame.addr == `ACFG_ADDR_POWER) begin
                power_next = frame.data & `ACFG_MASK_POWER;
            end else if (frame.addr == `ACFG_ADDR_DRIVE) begin
                drive_next = frame.data & `ACFG_MASK_DRIVE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            readback_reg <= `ACFG_RST_READBACK;
            sync_reg <= `ACFG_RST_SYNC;
            clamp_reg <= `ACFG_RST_CLAMP;
            power_reg <= `ACFG_RST_POWER;
            drive_reg <= `ACFG_RST_DRIVE;
        end else begin
            readback_reg <= readback_next;
            sync_reg <= sync_next;
            clamp_reg <= clamp_next;
            power_reg <= power_next;
            drive_reg <= drive_next;
        end
    end

    // ------------------------------------------------------------
    // Readback mux
    // ------------------------------------------------------------
    always_comb begin
        read_data = 16'h0000;
        if (cur_addr == `ACFG_ADDR_READBACK) begin
            read_data = readback_reg;
        end else if (cur_addr == `ACFG_ADDR_SYNC) begin
            read_data = sync_reg;
        end else if (cur_addr == `ACFG_ADDR_CLAMP) begin
            read_data = clamp_reg;
        end else if (cur_addr == `ACFG_ADDR_POWER) begin
            read_data = power_reg;
        end else if (cur_addr == `ACFG_ADDR_DRIVE) begin
            read_data = drive_reg;
        end
    end

    logic readback_on;
    assign readback_on = readback_reg[`ACFG_BIT_READBACK];
    // Data is only driven while the host holds the frame open.
    assign serial_data_output_pin_oe = readback_on & addr_valid &
        ~misc_s2_reg[3];
    assign serial_data_output_pin_o = serial_data_output_pin_oe &
        shift_out;

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    logic sync_en;
    assign sync_en = sync_reg[`ACFG_BIT_SYNC_EN];
    assign upper_address_enable = readback_reg[`ACFG_BIT_UPPER_ADDR];
    assign sync_pulse = sync_en & sync_rise;
    assign clamp_enable = clamp_reg[`ACFG_BIT_CLAMP_EN];
    assign clamp_strobe = clamp_enable & sync_rise;
    assign drive_current_word = drive_reg;
    assign data_driver_current = drive_reg[10:8];
    assign resolution_is_14bit = 1'b0;
    assign low_freq_noise_suppression = 1'b0;
    assign digital_gain = 4'h0;
    assign termination_enable = 1'b0;

    acfg_power_t power_cfg;
    assign power_cfg.pin_is_standby = power_reg[`ACFG_BIT_PIN_FUNC];
    assign power_cfg.global_powerdown = power_reg[`ACFG_BIT_GLOBAL_POWERDOWN];
    assign power_cfg.standby = power_reg[`ACFG_BIT_STANDBY];
    assign power_cfg.channel_sleep_bits = power_reg[7:0];

    acfg_power_ctrl u_power (
        .cfg(power_cfg),
        .powerdown_input(misc_s2_reg[1]),
        .state(power_state)
    );
endmodule // acfg_regs

// >>> acfg_regs_checker.sv
// Concurrent checks on the ports of the configuration bank.
// Assumes a bind onto acfg_regs; one clock domain with rst.
module acfg_regs_checker
    import acfg_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Watched ports.
    input wire logic sen_n,
    input wire logic sync_pin,
    input wire logic serial_data_output_pin_o,
    input wire logic serial_data_output_pin_oe,
    input wire logic sync_pulse,
    input wire logic clamp_enable,
    input wire logic clamp_strobe,
    input wire logic upper_address_enable,
    input wire logic [2:0] data_driver_current,
    input wire logic [15:0] drive_current_word,
    input wire logic resolution_is_14bit,
    input wire logic low_freq_noise_suppression,
    input wire logic [3:0] digital_gain,
    input wire logic termination_enable,
    input acfg_power_state_t power_state
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_idle_release;
        sen_n [*6] |-> !serial_data_output_pin_oe;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data pin driven outside a frame");
    property p_low_off;
        !serial_data_output_pin_oe |-> !serial_data_output_pin_o;
    endproperty
    a_low_off: assert property (p_low_off)
        else $error("data pin value while released");
    property p_sync_single;
        sync_pulse |=> !sync_pulse;
    endproperty
    a_sync_single: assert property (p_sync_single)
        else $error("sync pulse longer than one cycle");
    property p_sync_cause;
        !sync_pin [*6] |-> !sync_pulse;
    endproperty
    a_sync_cause: assert property (p_sync_cause)
        else $error("sync pulse without a pin edge");
    property p_clamp_cause;
        clamp_strobe |-> clamp_enable;
    endproperty
    a_clamp_cause: assert property (p_clamp_cause)
        else $error("clamp strobe while clamp disabled");
    property p_clamp_single;
        clamp_strobe |=> !clamp_strobe;
    endproperty
    a_clamp_single: assert property (p_clamp_single)
        else $error("clamp strobe longer than one cycle");
    property p_global_off;
        !power_state.chip_powered |-> !power_state.converters_on &&
            power_state.channel_on == 8'h00;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("parts powered in global power-down");
    property p_conv_off;
        !power_state.converters_on |-> power_state.channel_on == 8'h00;
    endproperty
    a_conv_off: assert property (p_conv_off)
        else $error("channel powered with converters off");
    property p_clocks;
        power_state.clocks_running == power_state.chip_powered;
    endproperty
    a_clocks: assert property (p_clocks)
        else $error("clock state differs from chip power");
    property p_fixed;
        !resolution_is_14bit && !low_freq_noise_suppression &&
            digital_gain == 4'h0 && !termination_enable;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed mode output not at default");
    property p_drive_field;
        data_driver_current == drive_current_word[10:8];
    endproperty
    a_drive_field: assert property (p_drive_field)
        else $error("drive field differs from drive word");
    property p_quiet;
        sen_n [*8] |=> $stable(drive_current_word) &&
            $stable(clamp_enable) && $stable(upper_address_enable);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("register changed without a frame");
    c_sync: cover property (sync_pulse);
    c_clamp: cover property (clamp_strobe);
    c_read: cover property ($rose(serial_data_output_pin_oe));
endmodule // acfg_regs_checker

// >>> acfg_host_model.sv
// Host side of the three-wire configuration port.
// Assumes a 50 MHz clock; each sclk phase lasts seven cycles.
module acfg_host_model (
    // Clock.
    input wire logic clock,
    // Serial pins.
    output logic sclk,
    output logic sen_n,
    output logic sdata,
    input wire logic sdo,
    input wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sdo_lvl = 1'b0;
    initial begin
        sclk = 1'b0;
        sen_n = 1'b1;
        sdata = 1'b0;
    end
    // A released data pin shows a changing level, never the last bit.
    always @(posedge clock) sdo_lvl <= sdo_oe ? sdo : ~sdo_lvl;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // ------------------------------------------------------------
    // Frame: eight address bits, then sixteen data bits, MSB first
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        logic [23:0] w;
        w = {a, d};
        q = 16'h0000;
        tick(1);
        sen_n = 1'b0;
        for (int k = 23; k >= 0; k--) begin
            sdata = w[k];
            tick(7);
            if (k < 16) q = {q[14:0], sdo_lvl};
            sclk = 1'b1;
            tick(7);
            sclk = 1'b0;
        end
        tick(7);
        sen_n = 1'b1;
        sdata = ~sdata;
        tick(8);
    endtask
endmodule // acfg_host_model

// >>> acfg_regs_test.sv
// Self-checking bench for the configuration register bank.
// Assumes acfg_host_model drives the serial port; clock is 50 MHz.
`include "acfg_cfg.svh"
module acfg_regs_test
    import acfg_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rst = 1'b1, pwr_pin = 1'b0, sync_pin = 1'b0;
    logic sclk, sen_n, sdata, sdo, sdo_oe, up_en, sync_pulse, clamp_en;
    logic clamp_strobe, res14, nsup, term;
    logic [2:0] cur;
    logic [3:0] gain;
    logic [15:0] drv, q, d;
    logic [15:0] mdl [0:31];
    logic [7:0] a;
    logic [7:0] tbl [0:4] = '{8'h01, 8'h02, 8'h09, 8'h0F, 8'h11};
    acfg_power_state_t pst;
    int err_count = 0, checks_done = 0, seed = 30, n_sync, n_clamp, n_oe;
    always #10 clock = ~clock;
    always @(posedge clock) begin
        n_sync += (sync_pulse === 1'b1);
        n_clamp += (clamp_strobe === 1'b1);
        n_oe += (sdo_oe === 1'b1);
    end
    acfg_host_model host (.clock, .sclk, .sen_n, .sdata, .sdo, .sdo_oe);
    acfg_regs uut (.clock, .rst, .sclk, .sen_n, .sdata,
        .serial_data_output_pin_o(sdo), .serial_data_output_pin_oe(sdo_oe),
        .powerdown_input(pwr_pin), .sync_pin, .upper_address_enable(up_en),
        .sync_pulse, .clamp_enable(clamp_en), .clamp_strobe,
        .data_driver_current(cur), .drive_current_word(drv),
        .resolution_is_14bit(res14), .low_freq_noise_suppression(nsup),
        .digital_gain(gain), .termination_enable(term), .power_state(pst));
    task automatic chk(input string n, input logic [15:0] e, s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [15:0] msk(input logic [7:0] x);
        case (x)
            8'h01: return `ACFG_MASK_READBACK;
            8'h02: return `ACFG_MASK_SYNC;
            8'h09: return `ACFG_MASK_CLAMP;
            8'h0F: return `ACFG_MASK_POWER;
            8'h11: return `ACFG_MASK_DRIVE;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] pexp(input logic [15:0] f, input p);
        logic g, s;
        g = f[9] | (p & ~f[10]);
        s = f[8] | (p & f[10]);
        return {5'h00, ~g, ~g & ~s, ~g, (g | s) ? 8'h00 : ~f[7:0]};
    endfunction
    // ------------------------------------------------------------
    // Register model, bus tasks and port comparison
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] x, input logic [15:0] v);
        host.xfer(x, v, q);
        mdl[x] = v & msk(x);
        if (x == 8'h00 && v[0]) foreach (mdl[i]) mdl[i] = 16'h0000;
    endtask
    task automatic rd(input logic [7:0] x);
        host.xfer(x, mdl[x], q);
        chk("readback", mdl[x], q);
    endtask
    task automatic outs();
        host.tick(6);
        chk("power_state", pexp(mdl[15], pwr_pin), {5'h00, pst});
        chk("drive_word", mdl[17], drv);
        chk("driver_current", {13'h0, mdl[17][10:8]}, {13'h0, cur});
        chk("upper_addr", {15'h0000, mdl[1][4]}, {15'h0000, up_en});
        chk("clamp_en", {15'h0, mdl[9][10]}, {15'h0, clamp_en});
        chk("fixed", 16'h0000, {9'h000, res14, nsup, gain, term});
    endtask
    initial begin
        foreach (mdl[i]) mdl[i] = 16'h0000;
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        outs();
        chk("oe", 16'h0000, {15'h0000, sdo_oe});
        $display("reset test done");
        wr(8'h01, 16'h0001);
        for (int i = 0; i < 10; i++) begin
            a = tbl[i % 5];
            d = 16'($random(seed));
            if (a == 8'h01) d[0] = 1'b1;
            wr(a, d);
            rd(a);
            outs();
        end
        rd(8'h05);
        $display("readback test done");
        for (int j = 0; j < 16; j++) begin
            pwr_pin = j[3];
            wr(8'h0F, {5'h00, j[2:0], 8'($random(seed))});
            outs();
        end
        pwr_pin = 1'b0;
        $display("power test done");
        for (int j = 0; j < 4; j++) begin
            wr(8'h02, j[0] ? 16'h2000 : 16'h0000);
            wr(8'h09, j[1] ? 16'h0400 : 16'h0000);
            n_sync = 0;
            n_clamp = 0;
            sync_pin = 1'b1;
            host.tick(5);
            sync_pin = 1'b0;
            host.tick(8);
            chk("sync_pulses", 16'(j[0]), 16'(n_sync));
            chk("clamp_pulses", 16'(j[1]), 16'(n_clamp));
        end
        $display("sync test done");
        wr(8'h00, 16'h0001);
        outs();
        n_oe = 0;
        host.xfer(8'h0F, 16'h0000, q);
        chk("oe_cycles", 16'h0000, 16'(n_oe));
        wr(8'h01, 16'h0001);
        rd(8'h00);
        rd(8'h01);
        $display("soft reset test done");
        finish_test();
    end
    initial begin
        #1000000;
        err_count++;
        finish_test();
    end
endmodule // acfg_regs_test
bind acfg_regs acfg_regs_checker u_chk (.clock, .rst, .sen_n, .sync_pin,
    .serial_data_output_pin_o, .serial_data_output_pin_oe, .sync_pulse,
    .clamp_enable, .clamp_strobe, .upper_address_enable,
    .data_driver_current, .drive_current_word, .resolution_is_14bit,
    .low_freq_noise_suppression, .digital_gain, .termination_enable,
    .power_state);
